// ---- rtl/pcicfg_header_regs.sv ----
// Configuration header mirror registers with local and header access ports
//
// Notes on behaviour
// - Memory window two base sits at local 0xd018, mirroring header 0x18.
// - Memory window two base bits 31:20 are read/write, reset zero.
// - Size field selects memory window two span from 1MB to 512MB.
// - Memory window two prefetch flag, bit 3, reads fixed zero.
// - Memory window two bits 2:1 read 00, meaning 32-bit region.
// - Bit 0 of memory window base reads zero, memory space.
// - I/O base at local 0xd01c mirrors header 0x1c, bits 31:8 writable.
// - I/O window decodes a fixed 256 bytes from its base.
// - I/O base bit 0 reads fixed one, I/O space.
// - Subsystem word holds ID in 31:16, vendor in 15:0, reset zero.
// - Subsystem fields change only while load enable is one.
// - Data word two write under load enable loads the subsystem word.
// - Subsystem and latency words are inaccessible locally in agent mode.
// - Capability pointer bits 7:0 read fixed 0xdc.
// - Data word three write under load enable loads latency word.
// - Max latency field, bits 31:24, resets zero; units of 250ns.
// - Min grant field, bits 23:16, resets zero; units of 250ns.
// - Interrupt pin field, bits 15:8, resets zero; 05h-FFh reserved.
// - Interrupt line field is plain storage with no effect.
`timescale 1ns/1ns
`include "pcicfg_cfg.svh"
module pcicfg_header_regs
(
	// Clock and reset
	input  wire logic                         i_core_clk,
	input  wire logic                         i_reset,

	// Local control-space access
	input  wire pcicfg_pkg::pcicfg_local_req_t i_local_req,
	output wire logic [31:0]                  o_local_rdata,
	output wire logic                         o_local_ack,
	output wire logic                         o_local_err,

	// Configuration header access from the bus
	input  wire pcicfg_pkg::pcicfg_hdr_req_t  i_hdr_req,
	output wire logic [31:0]                  o_hdr_rdata,
	output wire logic                         o_hdr_ack,

	// Load-configuration path
	input  wire logic                         i_load_config_enable,
	input  wire logic                         i_config_data_word_two_wr,
	input  wire logic                         i_config_data_word_three_wr,
	input  wire logic [31:0]                  i_config_load_wdata,

	// Controller mode
	input  wire logic                         i_agent_mode,

	// Target window decode
	input  wire logic [`PCICFG_SIZE_W-1:0]    i_target_size_config_zero,
	input  wire logic                         i_target_addr_valid,
	input  wire logic [31:0]                  i_target_addr,
	output wire logic                         o_mem2_hit,
	output wire logic                         o_io_hit,

	// Stored header state
	output wire pcicfg_pkg::pcicfg_hdr_t      o_hdr,
	output wire logic                         o_int_pin_valid
);

	// Register state
	pcicfg_pkg::pcicfg_hdr_t hdr_q;
	pcicfg_pkg::pcicfg_hdr_t hdr_d;
	logic [31:0]             local_rdata_q;
	logic                    local_ack_q;
	logic                    local_err_q;
	logic [31:0]             hdr_rdata_q;
	logic                    hdr_ack_q;
	logic                    mem2_hit_q;
	logic                    io_hit_q;
	logic                    int_pin_valid_q;

	// Decode wires
	pcicfg_pkg::pcicfg_reg_id_t local_id;
	pcicfg_pkg::pcicfg_reg_id_t local_rd_id;
	pcicfg_pkg::pcicfg_reg_id_t hdr_id;
	wire logic [31:0]           local_word;
	wire logic [31:0]           hdr_word;
	wire logic                  local_blocked;
	wire logic                  local_unmapped;
	wire logic                  local_wr;
	wire logic                  hdr_wr;
	wire logic                  wr_mem2_local;
	wire logic                  wr_mem2_hdr;
	wire logic                  wr_io_local;
	wire logic                  wr_io_hdr;
	wire logic                  load_subsys;
	wire logic                  load_cfg2;
	wire logic                  mem2_match;
	wire logic                  io_match;

	function automatic pcicfg_pkg::pcicfg_reg_id_t local_decode
	(
		input logic [15:0] addr
	);
		pcicfg_pkg::pcicfg_reg_id_t id;
		id = pcicfg_pkg::PCICFG_REG_NONE;
		if (addr == `PCICFG_OFS_MEM2_BASE)
			id = pcicfg_pkg::PCICFG_REG_MEM2;
		else if (addr == `PCICFG_OFS_IO_BASE)
			id = pcicfg_pkg::PCICFG_REG_IO;
		else if (addr == `PCICFG_OFS_SUBSYS)
			id = pcicfg_pkg::PCICFG_REG_SUBSYS;
		else if (addr == `PCICFG_OFS_CAP_PTR)
			id = pcicfg_pkg::PCICFG_REG_CAP;
		else if (addr == `PCICFG_OFS_CFG2)
			id = pcicfg_pkg::PCICFG_REG_CFG2;
		return id;
	endfunction

	function automatic pcicfg_pkg::pcicfg_reg_id_t hdr_decode
	(
		input logic [7:0] offset
	);
		pcicfg_pkg::pcicfg_reg_id_t id;
		id = pcicfg_pkg::PCICFG_REG_NONE;
		if (offset == `PCICFG_HDR_MEM2_BASE)
			id = pcicfg_pkg::PCICFG_REG_MEM2;
		else if (offset == `PCICFG_HDR_IO_BASE)
			id = pcicfg_pkg::PCICFG_REG_IO;
		else if (offset == `PCICFG_HDR_SUBSYS)
			id = pcicfg_pkg::PCICFG_REG_SUBSYS;
		else if (offset == `PCICFG_HDR_CAP_PTR)
			id = pcicfg_pkg::PCICFG_REG_CAP;
		else if (offset == `PCICFG_HDR_CFG2)
			id = pcicfg_pkg::PCICFG_REG_CFG2;
		return id;
	endfunction

	// Address decoding for both access ports
	assign local_id = local_decode(i_local_req.addr);
	assign hdr_id = hdr_decode(i_hdr_req.offset);

	// Agent mode hides two words from the local side only
	assign local_blocked = i_agent_mode
		& ((local_id == pcicfg_pkg::PCICFG_REG_SUBSYS)
		| (local_id == pcicfg_pkg::PCICFG_REG_CFG2));
	assign local_unmapped = local_id == pcicfg_pkg::PCICFG_REG_NONE;
	assign local_rd_id = local_blocked
		? pcicfg_pkg::PCICFG_REG_NONE : local_id;

	// Write strobes
	assign local_wr = i_local_req.sel & i_local_req.we & ~local_blocked;
	assign hdr_wr = i_hdr_req.sel & i_hdr_req.we;
	assign wr_mem2_local = local_wr
		& (local_id == pcicfg_pkg::PCICFG_REG_MEM2);
	assign wr_mem2_hdr = hdr_wr
		& (hdr_id == pcicfg_pkg::PCICFG_REG_MEM2);
	assign wr_io_local = local_wr
		& (local_id == pcicfg_pkg::PCICFG_REG_IO);
	assign wr_io_hdr = hdr_wr
		& (hdr_id == pcicfg_pkg::PCICFG_REG_IO);

	// Subsystem and latency words only move through the load path
	assign load_subsys = i_load_config_enable
		& i_config_data_word_two_wr;
	assign load_cfg2 = i_load_config_enable
		& i_config_data_word_three_wr;

	// Next state; a header-side write wins over a local one in the same cycle
	always_comb
	begin
		hdr_d = hdr_q;
		if (wr_mem2_hdr)
			hdr_d.mem2_base = i_hdr_req.wdata[`PCICFG_MEM_BA_HI:
				`PCICFG_MEM_BA_LO];
		else if (wr_mem2_local)
			hdr_d.mem2_base = i_local_req.wdata[`PCICFG_MEM_BA_HI:
				`PCICFG_MEM_BA_LO];
		if (wr_io_hdr)
			hdr_d.io_base = i_hdr_req.wdata[`PCICFG_IO_BA_HI:
				`PCICFG_IO_BA_LO];
		else if (wr_io_local)
			hdr_d.io_base = i_local_req.wdata[`PCICFG_IO_BA_HI:
				`PCICFG_IO_BA_LO];
		if (load_subsys)
		begin
			hdr_d.subsys_id_field = i_config_load_wdata[
				`PCICFG_SUBSYS_ID_FIELD_HI:`PCICFG_SUBSYS_ID_FIELD_LO];
			hdr_d.subsys_vendor_field = i_config_load_wdata[
				`PCICFG_SUBSYS_VENDOR_FIELD_HI:`PCICFG_SUBSYS_VENDOR_FIELD_LO];
		end
		if (load_cfg2)
		begin
			hdr_d.max_latency_field = i_config_load_wdata[
				`PCICFG_ML_HI:`PCICFG_ML_LO];
			hdr_d.min_grant_field = i_config_load_wdata[
				`PCICFG_MG_HI:`PCICFG_MG_LO];
			hdr_d.interrupt_pin_field = i_config_load_wdata[
				`PCICFG_IP_HI:`PCICFG_IP_LO];
			hdr_d.interrupt_line_field = i_config_load_wdata[
				`PCICFG_IL_HI:`PCICFG_IL_LO];
		end
	end

	// Header state
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			hdr_q.mem2_base <= `PCICFG_RST_MEM_BA;
			hdr_q.io_base <= `PCICFG_RST_IO_BA;
			hdr_q.subsys_id_field <= `PCICFG_RST_ID16;
			hdr_q.subsys_vendor_field <= `PCICFG_RST_ID16;
			hdr_q.max_latency_field <= `PCICFG_RST_BYTE;
			hdr_q.min_grant_field <= `PCICFG_RST_BYTE;
			hdr_q.interrupt_pin_field <= `PCICFG_RST_BYTE;
			hdr_q.interrupt_line_field <= `PCICFG_RST_BYTE;
		end
		else
			hdr_q <= hdr_d;
	end

	// Read word assembly, one per port
	pcicfg_rd_mux u_local_mux
	(
		.i_hdr  (hdr_q),
		.i_id   (local_rd_id),
		.o_word (local_word)
	);

	pcicfg_rd_mux u_hdr_mux
	(
		.i_hdr  (hdr_q),
		.i_id   (hdr_id),
		.o_word (hdr_word)
	);

	// Local answer one cycle after the request; refused reads return zero
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			local_rdata_q <= `PCICFG_ZERO_WORD;
			local_ack_q <= 1'b0;
			local_err_q <= 1'b0;
		end
		else
		begin
			local_ack_q <= i_local_req.sel;
			local_err_q <= i_local_req.sel
				& (local_unmapped | local_blocked);
			if (i_local_req.sel & ~i_local_req.we)
				local_rdata_q <= local_word;
			else
				local_rdata_q <= `PCICFG_ZERO_WORD;
		end
	end

	// Header-side answer, same timing as the local one
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			hdr_rdata_q <= `PCICFG_ZERO_WORD;
			hdr_ack_q <= 1'b0;
		end
		else
		begin
			hdr_ack_q <= i_hdr_req.sel;
			if (i_hdr_req.sel & ~i_hdr_req.we)
				hdr_rdata_q <= hdr_word;
			else
				hdr_rdata_q <= `PCICFG_ZERO_WORD;
		end
	end

	// Window compare against the stored bases
	pcicfg_win_decode u_win
	(
		.i_mem2_base  (hdr_q.mem2_base),
		.i_io_base    (hdr_q.io_base),
		.i_size_sel   (i_target_size_config_zero),
		.i_addr       (i_target_addr),
		.o_mem2_match (mem2_match),
		.o_io_match   (io_match)
	);

	// Hits are registered so the data path sees a clean level
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			mem2_hit_q <= 1'b0;
			io_hit_q <= 1'b0;
			int_pin_valid_q <= 1'b0;
		end
		else
		begin
			mem2_hit_q <= i_target_addr_valid & mem2_match;
			io_hit_q <= i_target_addr_valid & io_match;
			// Reserved pin codes are stored but flagged as unusable
			int_pin_valid_q <= (hdr_q.interrupt_pin_field
				!= `PCICFG_INT_PIN_NONE)
				& (hdr_q.interrupt_pin_field
				<= `PCICFG_INT_PIN_MAX);
		end
	end

	// Outputs
	assign o_local_rdata = local_rdata_q;
	assign o_local_ack = local_ack_q;
	assign o_local_err = local_err_q;
	assign o_hdr_rdata = hdr_rdata_q;
	assign o_hdr_ack = hdr_ack_q;
	assign o_mem2_hit = mem2_hit_q;
	assign o_io_hit = io_hit_q;
	assign o_hdr = hdr_q;
	assign o_int_pin_valid = int_pin_valid_q;

endmodule

// ---- rtl/pcicfg_rd_mux.sv ----
// Read word assembly for one register of the header mirror
`timescale 1ns/1ns
`include "pcicfg_cfg.svh"
module pcicfg_rd_mux
(
	// Stored header state
	input  wire pcicfg_pkg::pcicfg_hdr_t    i_hdr,
	// Register selected
	input  wire pcicfg_pkg::pcicfg_reg_id_t i_id,
	// Assembled word
	output wire logic [31:0]                o_word
);

	wire logic [31:0] mem2_word;
	wire logic [31:0] io_word;
	wire logic [31:0] subsys_word;
	wire logic [31:0] cap_word;
	wire logic [31:0] cfg2_word;

	// Reserved bits are packed as zero
	assign mem2_word = {i_hdr.mem2_base, 16'h0000,
		`PCICFG_MEM_PREFETCH, `PCICFG_MEM_TYPE,
		`PCICFG_MEM_SPACE};
	assign io_word = {i_hdr.io_base, 7'h00,
		`PCICFG_IO_SPACE};
	assign subsys_word = {i_hdr.subsys_id_field,
		i_hdr.subsys_vendor_field};
	assign cap_word = {24'h000000, `PCICFG_CAP_OFFSET};
	assign cfg2_word = {i_hdr.max_latency_field, i_hdr.min_grant_field,
		i_hdr.interrupt_pin_field,
		i_hdr.interrupt_line_field};

	assign o_word =
		(i_id == pcicfg_pkg::PCICFG_REG_MEM2)   ? mem2_word :
		(i_id == pcicfg_pkg::PCICFG_REG_IO)     ? io_word :
		(i_id == pcicfg_pkg::PCICFG_REG_SUBSYS) ? subsys_word :
		(i_id == pcicfg_pkg::PCICFG_REG_CAP)    ? cap_word :
		(i_id == pcicfg_pkg::PCICFG_REG_CFG2)   ? cfg2_word :
		`PCICFG_ZERO_WORD;

endmodule

// ---- rtl/pcicfg_win_decode.sv ----
// Target window address compare for memory window two and the I/O window
`timescale 1ns/1ns
`include "pcicfg_cfg.svh"
module pcicfg_win_decode
(
	// Programmed bases
	input  wire logic [11:0]               i_mem2_base,
	input  wire logic [23:0]               i_io_base,
	// Size select, a one leaves that address bit out of the compare
	input  wire logic [`PCICFG_SIZE_W-1:0] i_size_sel,
	// Address under test
	input  wire logic [31:0]               i_addr,
	// Compare results
	output wire logic                      o_mem2_match,
	output wire logic                      o_io_match
);

	wire logic [11:0] mem_mask;

	// Top three bits always compared, so the window never exceeds 512MB
	assign mem_mask = {`PCICFG_TOP_MASK, ~i_size_sel};
	assign o_mem2_match =
		((i_addr[`PCICFG_MEM_BA_HI:`PCICFG_MEM_BA_LO] ^ i_mem2_base)
		& mem_mask) == 12'h000;
	assign o_io_match =
		i_addr[`PCICFG_IO_BA_HI:`PCICFG_IO_BA_LO] == i_io_base;

endmodule

// ---- shared/pcicfg_cfg.svh ----
// Offsets, field positions, reset and fixed values of the header mirror
`ifndef PCICFG_CFG_SVH
`define PCICFG_CFG_SVH

// Local control-space offsets
`define PCICFG_OFS_MEM2_BASE 16'hd018
`define PCICFG_OFS_IO_BASE 16'hd01c
`define PCICFG_OFS_SUBSYS 16'hd02c
`define PCICFG_OFS_CAP_PTR 16'hd034
`define PCICFG_OFS_CFG2 16'hd03c

// Configuration header offsets mirrored by the registers above
`define PCICFG_HDR_MEM2_BASE 8'h18
`define PCICFG_HDR_IO_BASE 8'h1c
`define PCICFG_HDR_SUBSYS 8'h2c
`define PCICFG_HDR_CAP_PTR 8'h34
`define PCICFG_HDR_CFG2 8'h3c

// Field positions
`define PCICFG_MEM_BA_HI 31
`define PCICFG_MEM_BA_LO 20
`define PCICFG_IO_BA_HI 31
`define PCICFG_IO_BA_LO 8
`define PCICFG_SUBSYS_ID_FIELD_HI 31
`define PCICFG_SUBSYS_ID_FIELD_LO 16
`define PCICFG_SUBSYS_VENDOR_FIELD_HI 15
`define PCICFG_SUBSYS_VENDOR_FIELD_LO 0
`define PCICFG_ML_HI 31
`define PCICFG_ML_LO 24
`define PCICFG_MG_HI 23
`define PCICFG_MG_LO 16
`define PCICFG_IP_HI 15
`define PCICFG_IP_LO 8
`define PCICFG_IL_HI 7
`define PCICFG_IL_LO 0

// Reset values
`define PCICFG_RST_MEM_BA 12'h000
`define PCICFG_RST_IO_BA 24'h000000
`define PCICFG_RST_ID16 16'h0000
`define PCICFG_RST_BYTE 8'h00

// Fixed read-only values
`define PCICFG_MEM_PREFETCH 1'b0
`define PCICFG_MEM_TYPE 2'b00
`define PCICFG_MEM_SPACE 1'b0
`define PCICFG_IO_SPACE 1'b1
`define PCICFG_CAP_OFFSET 8'hdc
`define PCICFG_ZERO_WORD 32'h00000000

// Memory window size select width, always-compared top bits and interrupt pin code limits
`define PCICFG_SIZE_W 9
`define PCICFG_TOP_MASK 3'b111
`define PCICFG_INT_PIN_MAX 8'h04
`define PCICFG_INT_PIN_NONE 8'h00

`endif

// ---- shared/pcicfg_pkg.sv ----
// Types shared by the header mirror register bank
package pcicfg_pkg;

	typedef enum logic [2:0]
	{
		PCICFG_REG_NONE,
		PCICFG_REG_MEM2,
		PCICFG_REG_IO,
		PCICFG_REG_SUBSYS,
		PCICFG_REG_CAP,
		PCICFG_REG_CFG2
	} pcicfg_reg_id_t;

	typedef struct packed
	{
		logic [11:0] mem2_base;
		logic [23:0] io_base;
		logic [15:0] subsys_id_field;
		logic [15:0] subsys_vendor_field;
		logic [7:0]  max_latency_field;
		logic [7:0]  min_grant_field;
		logic [7:0]  interrupt_pin_field;
		logic [7:0]  interrupt_line_field;
	} pcicfg_hdr_t;

	typedef struct packed
	{
		logic        sel;
		logic        we;
		logic [15:0] addr;
		logic [31:0] wdata;
	} pcicfg_local_req_t;

	typedef struct packed
	{
		logic        sel;
		logic        we;
		logic [7:0]  offset;
		logic [31:0] wdata;
	} pcicfg_hdr_req_t;

endpackage

// ---- verif/pcicfg_header_regs_sva.sv ----
// Port-level checks for the header mirror register bank
`timescale 1ns/1ns
module pcicfg_header_regs_sva
(
	// Clock and reset
	input wire logic                          i_core_clk,
	input wire logic                          i_reset,
	// Local and header access
	input wire pcicfg_pkg::pcicfg_local_req_t i_local_req,
	input wire logic [31:0]                   o_local_rdata,
	input wire logic                          o_local_ack,
	input wire logic                          o_local_err,
	input wire pcicfg_pkg::pcicfg_hdr_req_t   i_hdr_req,
	// Load path, mode and decode
	input wire logic                          i_load_config_enable,
	input wire logic                          i_config_data_word_two_wr,
	input wire logic                          i_config_data_word_three_wr,
	input wire logic [31:0]                   i_config_load_wdata,
	input wire logic                          i_agent_mode,
	input wire logic                          i_target_addr_valid,
	input wire logic [31:0]                   i_target_addr,
	input wire logic                          o_io_hit,
	input wire pcicfg_pkg::pcicfg_hdr_t       o_hdr,
	input wire logic                          o_int_pin_valid
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	wire logic [15:0] la = i_local_req.addr;
	// A header write in the same cycle wins, so it masks local write checks
	wire logic hw = i_hdr_req.sel && i_hdr_req.we;
	wire logic mp = la inside {16'hd018, 16'hd01c, 16'hd02c, 16'hd034,
		16'hd03c};
	wire logic iom = i_target_addr_valid
		&& i_target_addr[31:8] == o_hdr.io_base;
	wire logic pv = o_hdr.interrupt_pin_field inside {[8'h01:8'h04]};
	wire logic [31:0] sid = {o_hdr.subsys_id_field,
		o_hdr.subsys_vendor_field};
	wire logic [31:0] cw = {o_hdr.max_latency_field, o_hdr.min_grant_field,
		o_hdr.interrupt_pin_field, o_hdr.interrupt_line_field};
	wire logic ld3 = i_load_config_enable && i_config_data_word_three_wr;
	sequence s_lrd(logic [15:0] a);
		i_local_req.sel && !i_local_req.we && la == a;
	endsequence
	sequence s_lwr(logic [15:0] a);
		i_local_req.sel && i_local_req.we && la == a && !hw;
	endsequence

	a_local_ack_next: assert property (1 |=>
		o_local_ack == $past(i_local_req.sel))
		else $error("ack not one cycle after request");
	a_mem2_write: assert property (s_lwr(16'hd018) |=>
		o_hdr.mem2_base == $past(i_local_req.wdata[31:20]))
		else $error("memory base not written");
	a_io_write: assert property (s_lwr(16'hd01c) |=>
		o_hdr.io_base == $past(i_local_req.wdata[31:8]))
		else $error("io base not written");
	a_mem2_read: assert property (s_lrd(16'hd018) |=>
		o_local_rdata == {$past(o_hdr.mem2_base), 20'h00000})
		else $error("memory base read word wrong");
	a_io_read: assert property (s_lrd(16'hd01c) |=>
		o_local_rdata == {$past(o_hdr.io_base), 8'h01})
		else $error("io base read word wrong");
	a_cap_fixed: assert property (s_lrd(16'hd034) |=>
		o_local_rdata == 32'h000000dc)
		else $error("capability pointer wrong");
	a_agent_block: assert property (i_local_req.sel && i_agent_mode
		&& la inside {16'hd02c, 16'hd03c} |=> o_local_err
		&& o_local_rdata == 32'h00000000)
		else $error("agent mode access not refused");
	a_unmapped_err: assert property (i_local_req.sel && !mp |=>
		o_local_err && o_local_rdata == 32'h00000000)
		else $error("unmapped access not refused");
	a_subsys_load: assert property (i_load_config_enable
		&& i_config_data_word_two_wr |=> sid == $past(i_config_load_wdata))
		else $error("subsystem word not loaded");
	a_subsys_hold: assert property (!(i_load_config_enable
		&& i_config_data_word_two_wr) |=> $stable(sid))
		else $error("subsystem word changed without load");
	a_cfg2_load: assert property (ld3 |=>
		cw == $past(i_config_load_wdata))
		else $error("latency word not loaded");
	a_cfg2_hold: assert property (!ld3 |=> $stable(cw))
		else $error("latency word changed without load");
	a_io_decode: assert property (1 |=> o_io_hit == $past(iom))
		else $error("io window hit wrong");
	a_pin_valid: assert property (1 |=> o_int_pin_valid == $past(pv))
		else $error("interrupt pin valid wrong");
endmodule
bind pcicfg_header_regs pcicfg_header_regs_sva pcicfg_header_regs_sva_i
(
	.i_core_clk                  (i_core_clk),
	.i_reset                     (i_reset),
	.i_local_req                 (i_local_req),
	.o_local_rdata               (o_local_rdata),
	.o_local_ack                 (o_local_ack),
	.o_local_err                 (o_local_err),
	.i_hdr_req                   (i_hdr_req),
	.i_load_config_enable        (i_load_config_enable),
	.i_config_data_word_two_wr   (i_config_data_word_two_wr),
	.i_config_data_word_three_wr (i_config_data_word_three_wr),
	.i_config_load_wdata         (i_config_load_wdata),
	.i_agent_mode                (i_agent_mode),
	.i_target_addr_valid         (i_target_addr_valid),
	.i_target_addr               (i_target_addr),
	.o_io_hit                    (o_io_hit),
	.o_hdr                       (o_hdr),
	.o_int_pin_valid             (o_int_pin_valid)
);

// ---- verif/pcicfg_header_regs_tb_top.sv ----
// Self-checking bench for the header mirror register bank
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module pcicfg_header_regs_tb_top;
	logic                         clk = 1'b0;
	logic                         rst = 1'b1;
	pcicfg_pkg::pcicfg_local_req_t lreq = '0;
	pcicfg_pkg::pcicfg_hdr_req_t  hreq;
	logic [31:0]                  lrd, hrd, lwd;
	logic                         lack, lerr, hack, len, w2, w3;
	logic                         agent = 1'b0;
	logic [8:0]                   size = 9'h000;
	logic                         tv = 1'b0;
	logic [31:0]                  ta = 32'h00000000;
	logic                         mhit, ihit, pinv;
	pcicfg_pkg::pcicfg_hdr_t      hdr;
	int                           err_count = 0;
	int                           cmp_count = 0;
	logic [15:0] la[5] = '{16'hd018, 16'hd01c, 16'hd02c, 16'hd034, 16'hd03c};
	logic [7:0]  ha[5] = '{8'h18, 8'h1c, 8'h2c, 8'h34, 8'h3c};
	logic [31:0] rv[5] = '{32'h0, 32'h1, 32'h0, 32'hdc, 32'h0};

	always #25 clk = ~clk;

	pcicfg_header_regs pcicfg_header_regs_i (.i_core_clk(clk),
		.i_reset(rst), .i_local_req(lreq), .o_local_rdata(lrd),
		.o_local_ack(lack), .o_local_err(lerr), .i_hdr_req(hreq),
		.o_hdr_rdata(hrd), .o_hdr_ack(hack), .i_load_config_enable(len),
		.i_config_data_word_two_wr(w2), .i_config_data_word_three_wr(w3),
		.i_config_load_wdata(lwd), .i_agent_mode(agent),
		.i_target_size_config_zero(size), .i_target_addr_valid(tv),
		.i_target_addr(ta), .o_mem2_hit(mhit), .o_io_hit(ihit),
		.o_hdr(hdr), .o_int_pin_valid(pinv));
	pcicfg_host_model pcicfg_host_model_i (.i_core_clk(clk),
		.o_hdr_req(hreq), .i_hdr_rdata(hrd), .i_hdr_ack(hack),
		.o_load_config_enable(len), .o_config_data_word_two_wr(w2),
		.o_config_data_word_three_wr(w3), .o_config_load_wdata(lwd));

	task automatic lrw(input logic we, input logic [15:0] a,
		input logic [31:0] w, output logic [31:0] r, output logic e);
		@(posedge clk);
		#1 lreq = '{1'b1, we, a, w};
		@(posedge clk);
		#1 lreq.sel = 1'b0;
		`CHK(lack, 1'b1)
		r = lrd;
		e = lerr;
	endtask
	task automatic lchk(input logic [15:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		lrw(1'b0, a, 32'h0, r, e);
		`CHK(r, x)
	endtask
	task automatic s_reset();
		logic [31:0] r;
		for (int k = 0; k < 5; k++)
		begin
			lchk(la[k], rv[k]);
			pcicfg_host_model_i.cfg(1'b0, ha[k], 32'h0, r);
			`CHK(r, rv[k])
		end
	endtask
	task automatic s_bars();
		logic [31:0] r;
		logic e;
		lrw(1'b1, 16'hd018, 32'hffffffff, r, e);
		lchk(16'hd018, 32'hfff00000);
		lrw(1'b1, 16'hd01c, 32'hffffffff, r, e);
		lchk(16'hd01c, 32'hffffff01);
		pcicfg_host_model_i.cfg(1'b1, 8'h18, 32'h12345678, r);
		lchk(16'hd018, 32'h12300000);
		pcicfg_host_model_i.cfg(1'b1, 8'h1c, 32'habcdef55, r);
		lchk(16'hd01c, 32'habcdef01);
		lrw(1'b1, 16'hd034, 32'h0, r, e);
		lchk(16'hd034, 32'h000000dc);
	endtask
	task automatic s_load();
		logic [31:0] r;
		logic e;
		lrw(1'b1, 16'hd02c, 32'hffffffff, r, e);
		pcicfg_host_model_i.load(1'b0, 1'b0, 32'h11112222);
		lchk(16'hd02c, 32'h0);
		pcicfg_host_model_i.load(1'b1, 1'b0, 32'h5a5aa5a5);
		lchk(16'hd02c, 32'h5a5aa5a5);
		pcicfg_host_model_i.load(1'b1, 1'b1, 32'h11220344);
		lrw(1'b1, 16'hd03c, 32'h0, r, e);
		lchk(16'hd03c, 32'h11220344);
		`CHK(pinv, 1'b1)
		pcicfg_host_model_i.load(1'b1, 1'b1, 32'h11220544);
		lchk(16'hd03c, 32'h11220544);
		`CHK(pinv, 1'b0)
		pcicfg_host_model_i.load(1'b0, 1'b1, 32'hffffffff);
		lchk(16'hd03c, 32'h11220544);
	endtask
	task automatic s_agent();
		logic [31:0] r;
		logic e;
		agent = 1'b1;
		for (int k = 2; k < 5; k += 2)
		begin
			lrw(1'b0, la[k], 32'h0, r, e);
			`CHK({e, r}, 33'h100000000)
		end
		pcicfg_host_model_i.cfg(1'b0, 8'h2c, 32'h0, r);
		`CHK(r, 32'h5a5aa5a5)
		agent = 1'b0;
		lrw(1'b0, 16'hd020, 32'h0, r, e);
		`CHK({e, r}, 33'h100000000)
	endtask
	task automatic s_decode();
		// Size select, address, expected memory and io hits
		logic [42:0] t[7] = '{{9'h000, 32'h12300000, 2'b10},
			{9'h000, 32'h12400000, 2'b00}, {9'h1ff, 32'h13f00000, 2'b10},
			{9'h1ff, 32'h32300000, 2'b00}, {9'h000, 32'habcdef00, 2'b01},
			{9'h000, 32'habcdeeff, 2'b00}, {9'h000, 32'habcdf000, 2'b00}};
		for (int k = 0; k < 7; k++)
		begin
			@(posedge clk);
			#1 size = t[k][42:34];
			tv = 1'b1;
			ta = t[k][33:2];
			@(posedge clk);
			#1 tv = 1'b0;
			`CHK({mhit, ihit}, t[k][1:0])
		end
	endtask
	// Reset in mid-run must clear every written and loaded field
	task automatic s_rerst();
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		`CHK({lack, lerr, mhit, ihit, pinv}, 5'h00)
		s_reset();
	endtask
	task automatic summarize();
		$display("Comparisons %0d, errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		s_reset();
		s_bars();
		s_load();
		s_agent();
		s_decode();
		s_rerst();
		summarize();
	end
	// Guard against a hung run
	initial
	begin
		#1000000;
		err_count++;
		summarize();
	end
endmodule

// ---- verif/pcicfg_host_model.sv ----
// Configuration host: header cycles and configuration memory loads
`timescale 1ns/1ns
module pcicfg_host_model
(
	// Clock
	input  wire logic                  i_core_clk,
	// Header port
	output pcicfg_pkg::pcicfg_hdr_req_t o_hdr_req,
	input  wire logic [31:0]           i_hdr_rdata,
	input  wire logic                  i_hdr_ack,
	// Load path
	output logic                       o_load_config_enable,
	output logic                       o_config_data_word_two_wr,
	output logic                       o_config_data_word_three_wr,
	output logic [31:0]                o_config_load_wdata
);
	initial
	begin
		o_hdr_req = '{1'b0, 1'b0, 8'h00, 32'h00000000};
		o_load_config_enable = 1'b0;
		o_config_data_word_two_wr = 1'b0;
		o_config_data_word_three_wr = 1'b0;
		o_config_load_wdata = 32'h00000000;
	end
	// One header cycle; idle data is inverted so stale values never match
	task automatic cfg(input logic we, input logic [7:0] ofs,
		input logic [31:0] w, output logic [31:0] r);
		@(posedge i_core_clk);
		#1 o_hdr_req = '{1'b1, we, ofs, w};
		@(posedge i_core_clk);
		#1 o_hdr_req.sel = 1'b0;
		o_hdr_req.wdata = ~w;
		r = i_hdr_ack ? i_hdr_rdata : ~i_hdr_rdata;
	endtask
	// Subsystem and latency words come from configuration memory
	task automatic load(input logic en, input logic three,
		input logic [31:0] w);
		@(posedge i_core_clk);
		#1 o_load_config_enable = en;
		o_config_data_word_two_wr = !three;
		o_config_data_word_three_wr = three;
		o_config_load_wdata = w;
		@(posedge i_core_clk);
		#1 o_config_data_word_two_wr = 1'b0;
		o_config_data_word_three_wr = 1'b0;
		o_load_config_enable = 1'b0;
		o_config_load_wdata = ~w;
	endtask
endmodule
